// [rtl/sls_link_status.v]
// Serial link fault flags, interface configuration and converter status.
//
// How it works
// R1 - Frame start before initialisation done sets the not-ready flag, bit 7.
// R2 - Frame ending off a byte boundary, or empty, sets clock count flag 4.
// R3 - Host frames each transaction with chip select low throughout.
// R4 - With CRC on, missing or wrong final CRC byte sets flag bit 3.
// R5 - Writing a read-only address sets flag bit 2.
// R6 - Accessing only part of the 16-bit status word sets flag bit 1.
// R7 - Partial access is checked only while strict mode is set.
// R8 - Touching a nonexistent address sets flag bit 0.
// R9 - Status word lives at 0x14/0x15 and resets to 0x0060.
// R10 - Summary error bit is high while any enabled diagnostic flag is set.
// R11 - Reset flag resets to one, set by reset events, cleared by write one.
// R12 - Conversion pending bit mirrors the converter, resetting to one.
// R13 - Low status bits hold the channel of the previous conversion.
// R14 - Flags clear only where the host writes a one.
// R15 - Link fault flags sit at address 0x11.
// R16 - In strict mode the whole multibyte register moves in one access.
// R17 - Reserved status bits read zero and ignore writes.
// R18 - A fault arriving with its own clear keeps the flag set.
`timescale 1ns/1ns
`include "sls_regs.vh"

module sls_link_status #(
  parameter DIAG_W = 16
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Serial link pins
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  output reg sdo,
  output wire sdo_oe,
  // Device side events
  input wire init_done,
  input wire reset_event,
  input wire conv_pending_in,
  input wire conv_done,
  input wire [`SLS_CHAN_W-1:0] conv_channel,
  input wire [DIAG_W-1:0] diag_flags,
  input wire [DIAG_W-1:0] diag_enables,
  // Register contents
  output reg [7:0] link_fault_flags,
  output wire [15:0] status_word,
  output reg [7:0] iface_config
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ACTIVE = 2'h1;
  localparam [1:0] ST_IGNORE = 2'h2;
  localparam [15:0] STAT_RST = `SLS_STAT_RESET;

  // ============================================================
  // Functions
  function [7:0] crc8_bit;
    input [7:0] c;
    input b;
    reg fb;
    begin
      fb = c[7] ^ b;
      crc8_bit = {c[6:0], 1'b0} ^ (fb ? `SLS_CRC_POLY : 8'h00);
    end
  endfunction

  function addr_exists;
    input [6:0] a;
    begin
      addr_exists = (a == `SLS_ADDR_CFG) || (a == `SLS_ADDR_FLT) ||
        (a == `SLS_ADDR_STAT_LO) || (a == `SLS_ADDR_STAT_HI);
    end
  endfunction

  function [7:0] rd_byte;
    input [6:0] a;
    input [7:0] cfg;
    input [7:0] flt;
    input [15:0] st;
    begin
      case (a)
        `SLS_ADDR_CFG: rd_byte = cfg;
        `SLS_ADDR_FLT: rd_byte = flt;
        `SLS_ADDR_STAT_LO: rd_byte = st[7:0];
        `SLS_ADDR_STAT_HI: rd_byte = st[15:8];
        default: rd_byte = 8'h00;
      endcase
    end
  endfunction

  // ============================================================
  // Pin conditioning
  wire cs_lvl;
  wire cs_rise;
  wire cs_fall;
  wire sclk_lvl;
  wire sclk_rise;
  wire sdi_lvl;

  sls_pin_sync #(.RST_VAL(1'b1)) u_cs (
    .clock(clock), .reset_n(reset_n), .pin(cs_n),
    .level(cs_lvl), .rise(cs_rise), .fall(cs_fall));
  sls_pin_sync #(.RST_VAL(1'b0)) u_sclk (
    .clock(clock), .reset_n(reset_n), .pin(sclk),
    .level(sclk_lvl), .rise(sclk_rise), .fall());
  sls_pin_sync #(.RST_VAL(1'b0)) u_sdi (
    .clock(clock), .reset_n(reset_n), .pin(sdi),
    .level(sdi_lvl), .rise(), .fall());

  // ============================================================
  // Frame state
  reg [1:0] state_reg;
  reg [2:0] bit_reg;
  reg [3:0] byte_reg;
  reg [7:0] shift_reg;
  reg rd_reg;
  reg [6:0] addr_reg;
  reg [7:0] crc_reg;
  reg [7:0] crc_mark_reg;
  reg [7:0] crc_prev_reg;
  reg [7:0] last_reg;
  reg [7:0] wbuf0_reg;
  reg [7:0] wbuf1_reg;
  reg pend_inval_reg;
  reg pend_ro_reg;
  reg acc_inval_reg;
  reg acc_ro_reg;
  reg [7:0] tx_reg;
  reg por_reg;
  reg pend_reg;
  reg main_err_reg;
  reg [`SLS_CHAN_W-1:0] chan_reg;

  wire active = (state_reg == ST_ACTIVE);
  wire [7:0] rx_byte = {shift_reg[6:0], sdi_lvl};
  wire [7:0] crc_next = crc8_bit(crc_reg, sdi_lvl);
  wire byte_done = active && sclk_rise && (bit_reg == 3'h7);
  wire [6:0] data_addr = addr_reg + {3'h0, byte_reg} - 7'h01;
  wire [6:0] ld_addr = (byte_reg == 4'h0) ? rx_byte[6:0] :
    addr_reg + {3'h0, byte_reg};
  wire rd_now = (byte_reg == 4'h0) ? rx_byte[7] : rd_reg;
  wire crc_on = (iface_config[7:6] == `SLS_CRC_ON) &&
    (iface_config[1:0] == `SLS_CRCB_ON);
  wire strict = iface_config[`SLS_CFG_STRICT];
  wire [7:0] ld_byte = rd_byte(ld_addr, iface_config, link_fault_flags,
    status_word);

  assign sdo_oe = active;
  // R17 R9
  assign status_word = {8'h00, main_err_reg, por_reg, pend_reg, 1'b0,
    chan_reg};

  // ============================================================
  // End of frame evaluation
  wire frame_end = active && cs_rise;
  wire [3:0] overhead = crc_on ? 4'h2 : 4'h1;
  wire [3:0] ndata = (byte_reg > overhead) ? byte_reg - overhead : 4'h0;
  wire [6:0] last_addr = addr_reg + {3'h0, ndata} - 7'h01;
  wire has_instr = (byte_reg != 4'h0);
  wire ccnt_err = (bit_reg != 3'h0) || !has_instr; // R2
  wire crc_miss = byte_reg < (rd_reg ? 4'h2 : 4'h3);
  wire crc_err = crc_on && has_instr &&
    (crc_miss || (last_reg != crc_prev_reg)); // R4
  wire inval_err = has_instr &&
    (acc_inval_reg || (!crc_on && pend_inval_reg)); // R8
  wire ro_err = has_instr && !rd_reg &&
    (acc_ro_reg || (!crc_on && pend_ro_reg)); // R5
  wire part_err = strict && has_instr && (ndata != 4'h0) &&
    ((addr_reg == `SLS_ADDR_STAT_HI) ||
     (last_addr == `SLS_ADDR_STAT_LO)); // R6 R7 R16
  wire any_err = ccnt_err | crc_err | inval_err | ro_err | part_err;
  wire commit = frame_end && !rd_reg && !any_err && (ndata != 4'h0);
  wire [6:0] addr1 = addr_reg + 7'h01;
  wire wr0 = commit;
  wire wr1 = commit && (ndata > 4'h1);

  function wr_hit;
    input [6:0] a;
    begin
      wr_hit = (wr0 && addr_reg == a) || (wr1 && addr1 == a);
    end
  endfunction

  wire [7:0] wdat_cfg = (addr_reg == `SLS_ADDR_CFG) ? wbuf0_reg : wbuf1_reg;
  wire [7:0] wdat_flt = (addr_reg == `SLS_ADDR_FLT) ? wbuf0_reg : wbuf1_reg;
  wire [7:0] wdat_stl = (addr_reg == `SLS_ADDR_STAT_LO) ? wbuf0_reg :
    wbuf1_reg;

  // ============================================================
  // Serial frame engine
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      bit_reg <= 3'h0;
      byte_reg <= 4'h0;
      shift_reg <= 8'h00;
      rd_reg <= 1'b0;
      addr_reg <= 7'h00;
      crc_reg <= `SLS_CRC_SEED;
      crc_mark_reg <= `SLS_CRC_SEED;
      crc_prev_reg <= `SLS_CRC_SEED;
      last_reg <= 8'h00;
      wbuf0_reg <= 8'h00;
      wbuf1_reg <= 8'h00;
      pend_inval_reg <= 1'b0;
      pend_ro_reg <= 1'b0;
      acc_inval_reg <= 1'b0;
      acc_ro_reg <= 1'b0;
      tx_reg <= 8'h00;
      sdo <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          sdo <= 1'b0;
          if (cs_fall) begin
            bit_reg <= 3'h0;
            byte_reg <= 4'h0;
            crc_reg <= `SLS_CRC_SEED;
            crc_mark_reg <= `SLS_CRC_SEED;
            crc_prev_reg <= `SLS_CRC_SEED;
            pend_inval_reg <= 1'b0;
            pend_ro_reg <= 1'b0;
            acc_inval_reg <= 1'b0;
            acc_ro_reg <= 1'b0;
            tx_reg <= 8'h00;
            state_reg <= init_done ? ST_ACTIVE : ST_IGNORE; // R1
          end
        end
        ST_ACTIVE: begin
          if (cs_rise) begin
            state_reg <= ST_IDLE;
          end else if (sclk_rise) begin
            shift_reg <= rx_byte;
            bit_reg <= bit_reg + 3'h1;
            crc_reg <= crc_next;
            if (bit_reg == 3'h7) begin
              if (byte_reg != 4'hf) begin
                byte_reg <= byte_reg + 4'h1;
              end
              last_reg <= rx_byte;
              crc_prev_reg <= crc_mark_reg;
              crc_mark_reg <= crc_next;
              if (byte_reg == 4'h0) begin
                rd_reg <= rx_byte[7];
                addr_reg <= rx_byte[6:0];
              end else begin
                // The last byte may be the CRC, so its checks lag one byte.
                acc_inval_reg <= acc_inval_reg | pend_inval_reg;
                acc_ro_reg <= acc_ro_reg | pend_ro_reg;
                pend_inval_reg <= !addr_exists(data_addr);
                // A lone high status byte is read-only; within the full word
                // it travels with the low byte, whose reset flag is clearable.
                pend_ro_reg <= (data_addr == `SLS_ADDR_STAT_HI) &&
                  (addr_reg == `SLS_ADDR_STAT_HI);
                if (byte_reg == 4'h1) begin
                  wbuf0_reg <= rx_byte;
                end
                if (byte_reg == 4'h2) begin
                  wbuf1_reg <= rx_byte;
                end
              end
              if (rd_now) begin
                sdo <= ld_byte[7];
                tx_reg <= {ld_byte[6:0], 1'b0};
              end else begin
                sdo <= 1'b0;
                tx_reg <= 8'h00;
              end
            end else begin
              sdo <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
            end
          end
        end
        ST_IGNORE: begin
          sdo <= 1'b0;
          if (cs_rise) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // Link fault flags and interface configuration
  reg [7:0] flt_set;
  reg [7:0] flt_clr;

  always @* begin
    flt_set = 8'h00;
    flt_set[`SLS_FLT_NRDY] = (state_reg == ST_IDLE) && cs_fall &&
      !init_done; // R1
    flt_set[`SLS_FLT_CCNT] = frame_end && ccnt_err; // R2 R3
    flt_set[`SLS_FLT_CRC] = frame_end && crc_err; // R4
    flt_set[`SLS_FLT_RO] = frame_end && ro_err; // R5
    flt_set[`SLS_FLT_PART] = frame_end && part_err; // R6
    flt_set[`SLS_FLT_INVAL] = frame_end && inval_err; // R8
    flt_clr = wr_hit(`SLS_ADDR_FLT) ?
      (wdat_flt & `SLS_FLT_W1C_MASK) : 8'h00; // R14 R15
  end

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      link_fault_flags <= `SLS_FLT_RESET;
      iface_config <= `SLS_CFG_RESET;
    end else begin
      link_fault_flags <= (link_fault_flags & ~flt_clr) | flt_set; // R18
      if (wr_hit(`SLS_ADDR_CFG)) begin
        iface_config <= (wdat_cfg & `SLS_CFG_WR_MASK) |
          (`SLS_CFG_RESET & ~`SLS_CFG_WR_MASK);
      end
    end
  end

  // ============================================================
  // Converter status word
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      por_reg <= STAT_RST[`SLS_STAT_POR];
      pend_reg <= STAT_RST[`SLS_STAT_PEND];
      main_err_reg <= STAT_RST[`SLS_STAT_MAIN];
      chan_reg <= {`SLS_CHAN_W{1'b0}};
    end else begin
      if (reset_event) begin
        por_reg <= 1'b1; // R11 R18
      end else if (wr_hit(`SLS_ADDR_STAT_LO) && wdat_stl[`SLS_STAT_POR]) begin
        por_reg <= 1'b0; // R11 R14
      end
      pend_reg <= conv_pending_in; // R12
      main_err_reg <= |(diag_flags & diag_enables); // R10
      if (conv_done) begin
        chan_reg <= conv_channel; // R13
      end
    end
  end

endmodule

// [rtl/sls_regs.vh]
// Register map, field positions and reset values of the link status block.
`ifndef SLS_REGS_VH
`define SLS_REGS_VH

// ============================================================
// Register addresses
`define SLS_ADDR_CFG 7'h10
`define SLS_ADDR_FLT 7'h11
`define SLS_ADDR_STAT_LO 7'h14
`define SLS_ADDR_STAT_HI 7'h15

// ============================================================
// Reset values
`define SLS_CFG_RESET 8'h27
`define SLS_FLT_RESET 8'h00
`define SLS_STAT_RESET 16'h0060

// ============================================================
// Fault flag positions
`define SLS_FLT_NRDY 7
`define SLS_FLT_CCNT 4
`define SLS_FLT_CRC 3
`define SLS_FLT_RO 2
`define SLS_FLT_PART 1
`define SLS_FLT_INVAL 0
`define SLS_FLT_W1C_MASK 8'h9f

// ============================================================
// Status word fields
`define SLS_STAT_MAIN 7
`define SLS_STAT_POR 6
`define SLS_STAT_PEND 5
`define SLS_CHAN_W 4

// ============================================================
// Interface configuration fields
`define SLS_CFG_WR_MASK 8'hd3
`define SLS_CFG_STRICT 5
`define SLS_CRC_ON 2'h1
`define SLS_CRCB_ON 2'h2
`define SLS_CRC_POLY 8'h07
`define SLS_CRC_SEED 8'h00

// ============================================================
// Pin synchroniser
`define SLS_SYNC_STAGES 3

`endif

// [rtl/sls_pin_sync.v]
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ns

module sls_pin_sync #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Pin and conditioned outputs
  input wire pin,
  output reg level,
  output wire rise,
  output wire fall
);

  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  wire level_next;

  // A change is accepted only once the second and third stages agree.
  assign level_next = (s2_reg == s3_reg) ? s3_reg : level;
  assign rise = level_next & ~level;
  assign fall = ~level_next & level;

  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level <= RST_VAL;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level <= level_next;
    end
  end

endmodule

// [tb/sls_link_status_sva.sv]
// Checker of link fault flags, configuration and status word behaviour.
`timescale 1ns/1ns
`include "sls_regs.vh"

module sls_link_status_sva #(
  parameter DIAG_W = 16
) (
  // Clock and reset
  input wire clock,
  input wire reset_n,
  // Link pins
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  input wire sdo,
  input wire sdo_oe,
  // Device side events
  input wire init_done,
  input wire reset_event,
  input wire conv_pending_in,
  input wire conv_done,
  input wire [`SLS_CHAN_W-1:0] conv_channel,
  input wire [DIAG_W-1:0] diag_flags,
  input wire [DIAG_W-1:0] diag_enables,
  // Register contents
  input wire [7:0] link_fault_flags,
  input wire [15:0] status_word,
  input wire [7:0] iface_config
);
  // ============================================================
  // Settling count, so that checks skip the edges right after reset.
  reg [1:0] up_reg;
  wire up;
  assign up = (up_reg == 2'h3);
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) up_reg <= 2'h0;
    else if (!up) up_reg <= up_reg + 2'h1;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ============================================================
  // Assertions
  main_err_follow_a: assert property (
    up |-> status_word[7] == |($past(diag_flags) & $past(diag_enables)))
    else $error("summary error bit wrong");
  pend_follow_a: assert property (
    up |-> status_word[5] == $past(conv_pending_in))
    else $error("pending bit wrong");
  chan_latch_a: assert property (
    up && conv_done |=> status_word[3:0] == $past(conv_channel))
    else $error("channel not latched");
  chan_hold_a: assert property (
    up && !conv_done |=> $stable(status_word[3:0]))
    else $error("channel changed without conversion");
  rsv_zero_a: assert property (
    status_word[15:8] == 8'h00 && !status_word[4]
    && link_fault_flags[6:5] == 2'h0) else $error("reserved bit set");
  por_set_a: assert property (
    reset_event |-> ##[1:2] status_word[6]) else $error("reset flag not set");
  cfg_fixed_a: assert property (
    iface_config[5] && !iface_config[3] && iface_config[2])
    else $error("fixed config bits wrong");
  clear_idle_a: assert property (
    up |-> ((($past(link_fault_flags) & ~link_fault_flags) == 8'h00) || cs_n))
    else $error("flag cleared inside a frame");
  fault_end_a: assert property (
    up |-> (((~$past(link_fault_flags) & link_fault_flags & 8'h1f) == 8'h00)
    || cs_n)) else $error("fault flag set inside a frame");
  oe_ready_a: assert property (
    $rose(sdo_oe) |-> init_done) else $error("frame served before init");
  cover property (conv_done);
  cover property ($rose(link_fault_flags[3]));
  cover property ($rose(sdo_oe));
endmodule

bind sls_link_status sls_link_status_sva #(.DIAG_W(DIAG_W)) u_sva (
  .clock(clock), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
  .sdo(sdo), .sdo_oe(sdo_oe), .init_done(init_done),
  .reset_event(reset_event), .conv_pending_in(conv_pending_in),
  .conv_done(conv_done), .conv_channel(conv_channel),
  .diag_flags(diag_flags), .diag_enables(diag_enables),
  .link_fault_flags(link_fault_flags), .status_word(status_word),
  .iface_config(iface_config));

// [tb/sls_host_model.sv]
// Serial host model that frames register transactions, mode 0, MSB first.
`timescale 1ns/1ns

module sls_host_model (
  // Link pins
  output logic cs_n,
  output logic sclk,
  output logic sdi,
  input wire sdo
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  // Sends all bytes less cut bits; rx holds what sdo gave during each byte.
  task automatic frame(input logic [7:0] tx[$], input int cut,
                       output logic [7:0] rx[$]);
    int n;
    logic [7:0] b;
    rx = {};
    b = 8'h00;
    n = 8 * tx.size() - cut;
    cs_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      sdi = tx[i / 8][7 - i % 8];
      #80 sclk = 1'b1;
      b = {b[6:0], sdo};
      if (i % 8 == 7) rx.push_back(b);
      #80 sclk = 1'b0;
    end
    sdi = ~sdi;
    #100 cs_n = 1'b1;
    #400;
  endtask
endmodule

// [tb/sls_link_status_tb.sv]
// Self-checking bench of the serial link status block.
`timescale 1ns/1ns

module sls_link_status_tb;
  logic clock, reset_n, init_done, reset_event, conv_pending_in, conv_done;
  logic [3:0] conv_channel;
  logic [15:0] diag_flags, diag_enables, exp_st;
  wire cs_n, sclk, sdi, sdo, sdo_oe;
  wire [7:0] link_fault_flags, iface_config;
  wire [15:0] status_word;
  int err_total, checks_done, seed;
  logic [7:0] q[$], rd[$];
  logic [15:0] cw [4] = '{16'h9100, 16'h1500, 16'hb000, 16'h9400};
  int cc [4] = '{4, 0, 0, 0};
  logic [7:0] ce [4] = '{8'h10, 8'h06, 8'h01, 8'h02};

  sls_link_status u_sls_link_status (.clock(clock), .reset_n(reset_n),
    .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
    .init_done(init_done), .reset_event(reset_event),
    .conv_pending_in(conv_pending_in), .conv_done(conv_done),
    .conv_channel(conv_channel), .diag_flags(diag_flags),
    .diag_enables(diag_enables), .link_fault_flags(link_fault_flags),
    .status_word(status_word), .iface_config(iface_config));
  sls_host_model u_sls_host_model (.cs_n(cs_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ============================================================
  // Helpers
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task give_verdict;
    if (err_total == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task run(input logic [23:0] w, input int nb, input int cut);
    q = {};
    for (int i = 0; i < nb; i++) q.push_back(w[23 - 8 * i -: 8]);
    u_sls_host_model.frame(q, cut, rd);
    repeat (20) @(posedge clock);
    #2;
  endtask
  task clr;
    run({8'h11, 8'h9f, 8'h00}, 2, 0);
    chk(link_fault_flags, 8'h00);
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] c;
    logic [15:0] d;
    c = 8'h00;
    d = {a, b};
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  // ============================================================
  // Main sequence
  initial begin
    reset_n = 1'b0;
    {init_done, reset_event, conv_done} = 3'h0;
    conv_pending_in = 1'b1;
    conv_channel = 4'h0;
    {diag_flags, diag_enables} = 32'h0;
    seed = $urandom(32'h10af);
    repeat (8) @(posedge clock);
    #2 reset_n = 1'b1;
    @(posedge clock);
    #2;
    chk(status_word, 16'h0060);
    chk({link_fault_flags, iface_config}, 16'h0027);
    run({8'h91, 16'h0000}, 2, 0);
    chk(link_fault_flags, 8'h80);
    init_done = 1'b1;
    clr();
    for (int i = 0; i < 4; i++) begin
      run({cw[i], 8'h00}, 2, cc[i]);
      chk(link_fault_flags, ce[i]);
      if (i == 2) chk(rd[1], 8'h00);
      clr();
    end
    repeat (4) begin
      {diag_flags, diag_enables} = $urandom;
      {conv_pending_in, conv_channel} = 5'($urandom);
      {conv_done, reset_event} = 2'h3;
      @(posedge clock);
      #2 {conv_done, reset_event} = 2'h0;
      exp_st = {8'h00, |(diag_flags & diag_enables), 1'b1, conv_pending_in,
                1'b0, conv_channel};
      run({8'h94, 16'h0000}, 3, 0);
      chk({rd[2], rd[1]}, exp_st);
      chk(status_word, exp_st);
      chk(link_fault_flags, 8'h00);
    end
    run({8'h14, 8'h40, 8'h00}, 3, 0);
    chk({link_fault_flags, 7'h00, status_word[6]}, 16'h0000);
    run({8'h10, 8'h42, 8'h00}, 2, 0);
    chk(iface_config, 8'h66);
    run({8'h11, 8'h00, 8'h00}, 2, 0);
    chk(link_fault_flags, 8'h08);
    run({8'h11, 8'h08, crc8(8'h11, 8'h08)}, 3, 0);
    chk(link_fault_flags, 8'h00);
    run({8'h11, 8'h00, ~crc8(8'h11, 8'h00)}, 3, 0);
    chk(link_fault_flags, 8'h08);
    reset_n = 1'b0;
    repeat (2) @(posedge clock);
    #2;
    chk({link_fault_flags, iface_config}, 16'h0027);
    chk(status_word[6], 1'b1);
    reset_n = 1'b1;
    @(posedge clock);
    #2;
    run({8'h91, 16'h0000}, 2, 0);
    chk(rd[1], 8'h00);
    give_verdict();
  end
  initial begin
    repeat (40000) @(posedge clock);
    err_total++;
    give_verdict();
  end
endmodule
